// ---- design/cst_pkg.sv ----
package cst_pkg;

  // Status word bit positions
  localparam int unsigned BIT_ARG_RANGE     = 31;
  localparam int unsigned BIT_ADDR_ALIGN    = 30;
  localparam int unsigned BIT_BLK_LEN       = 29;
  localparam int unsigned BIT_ERASE_ORDER   = 28;
  localparam int unsigned BIT_ERASE_SELECT  = 27;
  localparam int unsigned BIT_PROTECT_WRITE = 26;
  localparam int unsigned BIT_LOCKED        = 25;
  localparam int unsigned BIT_LOCK_FAIL     = 24;
  localparam int unsigned BIT_CMD_CHECK     = 23;
  localparam int unsigned BIT_BAD_CMD       = 22;
  localparam int unsigned BIT_ECC_FAIL      = 21;
  localparam int unsigned BIT_CONTROLLER    = 20;
  localparam int unsigned BIT_GENERAL       = 19;
  localparam int unsigned BIT_UNDERRUN      = 18;
  localparam int unsigned BIT_OVERRUN       = 17;
  localparam int unsigned BIT_ID_CFG        = 16;
  localparam int unsigned BIT_ERASE_SKIP    = 15;
  localparam int unsigned BIT_ECC_OFF       = 14;
  localparam int unsigned BIT_ERASE_RESET   = 13;
  localparam int unsigned BIT_STATE_LSB     = 9;
  localparam int unsigned BIT_BUF_EMPTY     = 8;
  localparam int unsigned BIT_APP           = 5;

  // Reset value of the sticky part of the status word
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  // Card state codes, 9 to 15 reserved
  localparam logic [3:0] ST_IDLE  = 4'h0;
  localparam logic [3:0] ST_READY = 4'h1;
  localparam logic [3:0] ST_IDENT = 4'h2;
  localparam logic [3:0] ST_STBY  = 4'h3;
  localparam logic [3:0] ST_TRAN  = 4'h4;
  localparam logic [3:0] ST_DATA  = 4'h5;
  localparam logic [3:0] ST_RCV   = 4'h6;
  localparam logic [3:0] ST_PRG   = 4'h7;
  localparam logic [3:0] ST_DIS   = 4'h8;

  // Line timing in link clock cycles
  localparam int unsigned CMD_TO_RESP_GAP_MIN = 2;
  localparam int unsigned CMD_TO_RESP_GAP_MAX = 64;
  localparam int unsigned IDENT_RESP_GAP      = 5;
  localparam int unsigned RESP_TO_CMD_GAP_MIN = 8;
  localparam int unsigned CMD_TO_CMD_GAP_MIN  = 8;
  localparam int unsigned WRITE_TO_DATA_MIN   = 2;
  localparam int unsigned RESP_GAP_DEFAULT    = 8;
  localparam int unsigned FRAME_BITS          = 48;
  // System clock cycles the core gets to post response-time flags
  localparam int unsigned CORE_WAIT           = 2;

  // Response kinds chosen by the card core
  typedef enum logic [1:0] {
    RK_NONE,
    RK_R1,
    RK_R1_NOPULL,
    RK_OPEN
  } cst_resp_kind_t;

  typedef struct packed {
    logic [5:0]  index;
    logic [31:0] arg;
  } cst_cmd_t;

  typedef struct packed {
    logic arg_range_fault;
    logic addr_align_fault;
    logic blk_length_fault;
    logic erase_order_fault;
    logic erase_select_fault;
    logic protect_write_fault;
    logic lock_fail;
    logic bad_cmd_flag;
    logic ecc_fail;
    logic controller_fault;
    logic general_fault;
    logic underrun_fault;
    logic overrun_fault;
    logic id_cfg_rewrite_fault;
    logic erase_skip;
    logic erase_reset;
    logic app_specific_flag;
  } cst_evt_t;

  typedef struct packed {
    logic       locked_flag;
    logic       ecc_off;
    logic       buf_empty;
    logic [3:0] state;
  } cst_lvl_t;

  typedef struct packed {
    cst_resp_kind_t kind;
    logic [5:0]     index;
    logic [31:0]    payload;
  } cst_resp_t;

endpackage : cst_pkg

// ---- design/cst_card_status.sv ----
`timescale 1ns/1ps

// Notes on behaviour
// - Keep a 32-bit status word; send it in every RK_R1 and RK_R1_NOPULL response.
// - Clear kinds: follow state, clear one command after valid one, clear on read.
// - Bit 31 argument arg_range_fault, reported in that response, clear on read.
// - Bit 30 misaligned address, at response or execution, clear on read.
// - Bit 29 block length not allowed or byte count mismatch, clear on read.
// - Bit 28 erase sequence error, bit 27 bad erase selection, clear on read.
// - Bit 26 write to a protected block, clear on read.
// - Bit 25 follows the card lock state.
// - Bit 24 lock or unlock failure or locked access, clear on read.
// - Bit 23 previous command CRC failed, cleared one command after valid one.
// - Bit 22 command illegal in state, cleared one command after valid one.
// - Bit 21 uncorrectable data, clear on read; bit 14 follows ECC disable.
// - Bit 20 controller error, bit 19 general error, clear on read.
// - Bit 18 stream read underrun, bit 17 stream write overrun, clear on read.
// - Bit 16 identification or configuration rewrite fault, clear on read.
// - Bit 15 erase skipped protected blocks, bit 13 erase cancelled, clear on read.
// - Bits 12:9 carry the current state code.
// - Bit 8 mirrors buffer empty.
// - Bit 5 application command flag; bits 7:6 and 4 read zero.
// - Response starts 2 to 64 cycles after command end; RK_R1 sends pull-up bits first.
// - Open-drain identification responses start exactly 5 cycles after command.
// - Commands and responses change on the rising host clock edge.
module cst_card_status #(
  parameter int unsigned RESP_GAP = cst_pkg::RESP_GAP_DEFAULT
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  clk_link,
  input  wire logic                  cmd_in,
  output      logic                  cmd_out,
  output      logic                  cmd_oe_n,
  input  wire cst_pkg::cst_evt_t     evt,
  input  wire cst_pkg::cst_lvl_t     lvl,
  input  wire cst_pkg::cst_resp_kind_t resp_sel,
  input  wire logic [31:0]           ident_word,
  output      logic                  cmd_take,
  output      cst_pkg::cst_cmd_t     cmd_info,
  output      logic [31:0]           status_word
);

  // Gap must sit inside the legal window
  if (RESP_GAP < cst_pkg::CMD_TO_RESP_GAP_MIN || RESP_GAP > cst_pkg::CMD_TO_RESP_GAP_MAX)
  begin : g_bad_gap
    $error("RESP_GAP outside legal response window");
  end

  localparam logic [6:0] GAP_R1  = 7'(RESP_GAP);
  localparam logic [6:0] GAP_ID  = 7'(cst_pkg::IDENT_RESP_GAP);
  localparam logic [6:0] GAP_MAX = 7'(cst_pkg::CMD_TO_RESP_GAP_MAX);
  localparam logic [5:0] LAST_BIT = 6'(cst_pkg::FRAME_BITS - 1);
  localparam logic [5:0] END_CNT  = 6'(cst_pkg::FRAME_BITS);
  localparam logic [1:0] WAIT_LAST = 2'(cst_pkg::CORE_WAIT);

  // Serial CRC7 over the first 40 frame bits
  function automatic logic [6:0] cst_crc7(input logic [39:0] bits);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--)
    begin
      fb = bits[i] ^ c[6];
      c  = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    return c;
  endfunction : cst_crc7

  // Event pulses mapped onto their status positions
  function automatic logic [31:0] cst_evt_word(input cst_pkg::cst_evt_t e);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[cst_pkg::BIT_ARG_RANGE]     = e.arg_range_fault;
    w[cst_pkg::BIT_ADDR_ALIGN]    = e.addr_align_fault;
    w[cst_pkg::BIT_BLK_LEN]       = e.blk_length_fault;
    w[cst_pkg::BIT_ERASE_ORDER]   = e.erase_order_fault;
    w[cst_pkg::BIT_ERASE_SELECT]  = e.erase_select_fault;
    w[cst_pkg::BIT_PROTECT_WRITE] = e.protect_write_fault;
    w[cst_pkg::BIT_LOCK_FAIL]     = e.lock_fail;
    w[cst_pkg::BIT_BAD_CMD]       = e.bad_cmd_flag;
    w[cst_pkg::BIT_ECC_FAIL]      = e.ecc_fail;
    w[cst_pkg::BIT_CONTROLLER]    = e.controller_fault;
    w[cst_pkg::BIT_GENERAL]       = e.general_fault;
    w[cst_pkg::BIT_UNDERRUN]      = e.underrun_fault;
    w[cst_pkg::BIT_OVERRUN]       = e.overrun_fault;
    w[cst_pkg::BIT_ID_CFG]        = e.id_cfg_rewrite_fault;
    w[cst_pkg::BIT_ERASE_SKIP]    = e.erase_skip;
    w[cst_pkg::BIT_ERASE_RESET]   = e.erase_reset;
    w[cst_pkg::BIT_APP]           = e.app_specific_flag;
    return w;
  endfunction : cst_evt_word

  // Level fields, bits 7:6, 4 and 3:0 stay zero
  function automatic logic [31:0] cst_lvl_word(input cst_pkg::cst_lvl_t l);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[cst_pkg::BIT_LOCKED]    = l.locked_flag;
    w[cst_pkg::BIT_ECC_OFF]   = l.ecc_off;
    w[cst_pkg::BIT_STATE_LSB +: 4] = l.state;
    w[cst_pkg::BIT_BUF_EMPTY] = l.buf_empty;
    return w;
  endfunction : cst_lvl_word

  localparam logic [31:0] B_MASK = (32'h1 << cst_pkg::BIT_CMD_CHECK)
                                 | (32'h1 << cst_pkg::BIT_BAD_CMD);
  localparam logic [31:0] STATUS_RESET_C = cst_pkg::STATUS_RESET;

  // Link reset: asserts at once, releases on the link clock
  logic lrst_a;
  logic lrst;
  always_ff @(posedge clk_link or posedge rst)
  begin
    if (rst)
    begin
      lrst_a <= 1'b1;
      lrst   <= 1'b1;
    end
    else
    begin
      lrst_a <= 1'b0;
      lrst   <= lrst_a;
    end
  end

  // Link side: receive, gap timing and response shifter
  typedef enum logic [1:0] {L_IDLE, L_RECV, L_GAP, L_SEND} cst_lstate_t;
  cst_lstate_t        ls, next_ls;
  logic [47:0]        rx_sh, next_rx_sh;
  logic [5:0]         bit_cnt, next_bit_cnt;
  logic [6:0]         gap_cnt, next_gap_cnt;
  logic [47:0]        tx_sh, next_tx_sh;
  logic               tx_open, next_tx_open;
  cst_pkg::cst_cmd_t  lk_cmd, next_lk_cmd;
  logic               lk_crc_ok, next_lk_crc_ok;
  logic               req_tgl, next_req_tgl;
  logic               lk_out, next_lk_out;
  logic               lk_oe_n, next_lk_oe_n;
  logic               ack_s1, ack_s2, ack_seen, next_ack_seen;
  logic               ack_tgl;
  cst_pkg::cst_resp_t sys_resp;
  logic [39:0]        tx_head;
  logic [47:0]        frame;
  logic               got_ack;

  // Ack toggle into the link domain
  always_ff @(posedge clk_link or posedge lrst)
  begin
    if (lrst)
    begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end
    else
    begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
    end
  end

  // Response frame, held stable by the system side after its ack
  always_comb
  begin
    got_ack = (ack_s2 != ack_seen);
    if (sys_resp.kind == cst_pkg::RK_OPEN)
      tx_head = {2'b00, 6'h3f, sys_resp.payload};
    else
      tx_head = {2'b00, sys_resp.index, sys_resp.payload};
    if (sys_resp.kind == cst_pkg::RK_OPEN)
      frame = {tx_head, 7'h7f, 1'b1};
    else
      frame = {tx_head, cst_crc7(tx_head), 1'b1};
  end

  // Line runs entirely on the rising host clock edge
  always_comb
  begin
    next_ls        = ls;
    next_rx_sh     = rx_sh;
    next_bit_cnt   = bit_cnt;
    next_gap_cnt   = gap_cnt;
    next_tx_sh     = tx_sh;
    next_tx_open   = tx_open;
    next_lk_cmd    = lk_cmd;
    next_lk_crc_ok = lk_crc_ok;
    next_req_tgl   = req_tgl;
    next_ack_seen  = ack_seen;
    next_lk_out    = 1'b1;
    next_lk_oe_n   = 1'b1;
    case (ls)
      L_IDLE:
      begin
        if (!cmd_in)
        begin
          next_rx_sh   = 48'h0000_0000_0000;
          next_bit_cnt = 6'h01;
          next_ls      = L_RECV;
        end
      end
      L_RECV:
      begin
        next_rx_sh   = {rx_sh[46:0], cmd_in};
        next_bit_cnt = bit_cnt + 6'h01;
        if (bit_cnt == LAST_BIT)
        begin
          // Frame complete on this edge: end bit sampled
          next_lk_cmd.index = rx_sh[44:39];
          next_lk_cmd.arg   = rx_sh[38:7];
          // Start bit is not shifted in: transmitter bit sits at rx_sh[45]
          next_lk_crc_ok    = rx_sh[45] && cmd_in
                           && (cst_crc7({1'b0, rx_sh[45:7]}) == rx_sh[6:0]);
          next_req_tgl      = ~req_tgl;
          next_gap_cnt      = 7'h01;
          next_ls           = L_GAP;
        end
      end
      L_GAP:
      begin
        next_gap_cnt = gap_cnt + 7'h01;
        if (got_ack && sys_resp.kind == cst_pkg::RK_NONE)
        begin
          next_ack_seen = ack_s2;
          next_ls       = L_IDLE;
        end
        else if (got_ack && sys_resp.kind == cst_pkg::RK_OPEN)
        begin
          if (gap_cnt == GAP_ID)
          begin
            next_ack_seen = ack_s2;
            next_tx_sh    = {frame[46:0], 1'b1};
            next_tx_open  = 1'b1;
            next_lk_out   = 1'b0;
            next_lk_oe_n  = 1'b0;
            next_bit_cnt  = 6'h01;
            next_ls       = L_SEND;
          end
          else if (gap_cnt > GAP_ID)
          begin
            next_ack_seen = ack_s2;
            next_ls       = L_IDLE;
          end
        end
        else if (got_ack && gap_cnt >= GAP_R1)
        begin
          next_ack_seen = ack_s2;
          next_tx_sh    = {frame[46:0], 1'b1};
          next_tx_open  = 1'b0;
          next_lk_out   = 1'b0;
          next_lk_oe_n  = 1'b0;
          next_bit_cnt  = 6'h01;
          next_ls       = L_SEND;
        end
        else if (gap_cnt >= GAP_MAX)
        begin
          next_ls = L_IDLE;         // Core never answered: stay silent
        end
        else if (got_ack && sys_resp.kind == cst_pkg::RK_R1 && gap_cnt >= 7'h02)
        begin
          next_lk_out  = 1'b1;
          next_lk_oe_n = 1'b0;
        end
      end
      L_SEND:
      begin
        next_tx_sh   = {tx_sh[46:0], 1'b1};
        next_bit_cnt = bit_cnt + 6'h01;
        // Open drain drives only the zero bits
        next_lk_out  = tx_open ? 1'b0 : tx_sh[47];
        next_lk_oe_n = tx_open ? tx_sh[47] : 1'b0;
        // End bit is driven too unless open drain; release only on the edge after it
        if (bit_cnt == END_CNT)
        begin
          next_lk_out  = 1'b1;
          next_lk_oe_n = 1'b1;
          next_ls      = L_IDLE;
        end
      end
      default:
      begin
        next_ls = L_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_link or posedge lrst)
  begin
    if (lrst)
    begin
      ls        <= L_IDLE;
      rx_sh     <= 48'h0000_0000_0000;
      bit_cnt   <= 6'h00;
      gap_cnt   <= 7'h00;
      tx_sh     <= 48'hffff_ffff_ffff;
      tx_open   <= 1'b0;
      lk_cmd    <= '0;
      lk_crc_ok <= 1'b0;
      req_tgl   <= 1'b0;
      ack_seen  <= 1'b0;
      lk_out    <= 1'b1;
      lk_oe_n   <= 1'b1;
    end
    else
    begin
      ls        <= next_ls;
      rx_sh     <= next_rx_sh;
      bit_cnt   <= next_bit_cnt;
      gap_cnt   <= next_gap_cnt;
      tx_sh     <= next_tx_sh;
      tx_open   <= next_tx_open;
      lk_cmd    <= next_lk_cmd;
      lk_crc_ok <= next_lk_crc_ok;
      req_tgl   <= next_req_tgl;
      ack_seen  <= next_ack_seen;
      lk_out    <= next_lk_out;
      lk_oe_n   <= next_lk_oe_n;
    end
  end

  assign cmd_out  = lk_out;
  assign cmd_oe_n = lk_oe_n;

  // System side: request sync, status word and response snapshot
  logic               req_s1, req_s2, req_s3;
  logic [31:0]        sticky, next_sticky;
  logic               busy, next_busy;
  logic [1:0]         wait_cnt, next_wait_cnt;
  logic               ack_r, next_ack_r;
  cst_pkg::cst_resp_t resp_r, next_resp_r;
  logic               take_r, next_take_r;
  cst_pkg::cst_cmd_t  info_r, next_info_r;
  logic [31:0]        stat_r, next_stat_r;
  logic [31:0]        live;
  logic               req_edge;

  always_comb
  begin
    req_edge      = req_s2 ^ req_s3;
    next_sticky   = sticky;
    next_busy     = busy;
    next_wait_cnt = wait_cnt;
    next_ack_r    = ack_r;
    next_resp_r   = resp_r;
    next_take_r   = 1'b0;
    next_info_r   = info_r;
    live          = sticky | cst_lvl_word(lvl);
    if (req_edge && !lk_crc_ok)
    begin
      // Bad frame: no answer, flag it for the next valid command
      next_resp_r.kind = cst_pkg::RK_NONE;
      next_ack_r       = ~ack_r;
      next_sticky[cst_pkg::BIT_CMD_CHECK] = 1'b1;
    end
    else if (req_edge)
    begin
      next_take_r   = 1'b1;
      next_info_r   = lk_cmd;
      next_busy     = 1'b1;
      next_wait_cnt = 2'h0;
    end
    else if (busy)
    begin
      next_wait_cnt = wait_cnt + 2'h1;
      if (wait_cnt == WAIT_LAST)
      begin
        // Snapshot includes flags posted this very cycle
        next_resp_r.kind    = resp_sel;
        next_resp_r.index   = info_r.index;
        next_resp_r.payload = (resp_sel == cst_pkg::RK_OPEN) ? ident_word
                            : (live | cst_evt_word(evt));
        next_ack_r          = ~ack_r;
        next_busy           = 1'b0;
        if (resp_sel != cst_pkg::RK_NONE && resp_sel != cst_pkg::RK_OPEN)
        begin
          // Reported bits clear, bar events posted this same cycle: read ones and one-command-late ones
          next_sticky = STATUS_RESET_C & ~B_MASK;
        end
      end
    end
    next_sticky = next_sticky | cst_evt_word(evt);
    next_stat_r = next_sticky | cst_lvl_word(lvl);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      req_s1   <= 1'b0;
      req_s2   <= 1'b0;
      req_s3   <= 1'b0;
      sticky   <= cst_pkg::STATUS_RESET;
      busy     <= 1'b0;
      wait_cnt <= 2'h0;
      ack_r    <= 1'b0;
      resp_r   <= '0;
      take_r   <= 1'b0;
      info_r   <= '0;
      stat_r   <= cst_pkg::STATUS_RESET;
    end
    else
    begin
      req_s1   <= req_tgl;
      req_s2   <= req_s1;
      req_s3   <= req_s2;
      sticky   <= next_sticky;
      busy     <= next_busy;
      wait_cnt <= next_wait_cnt;
      ack_r    <= next_ack_r;
      resp_r   <= next_resp_r;
      take_r   <= next_take_r;
      info_r   <= next_info_r;
      stat_r   <= next_stat_r;
    end
  end

  assign ack_tgl     = ack_r;
  assign sys_resp    = resp_r;
  assign cmd_take    = take_r;
  assign cmd_info    = info_r;
  assign status_word = stat_r;

endmodule : cst_card_status

// ---- bench/cst_card_status_asserts.sv ----
`timescale 1ns/1ps

module cst_card_status_asserts #(
  parameter int unsigned RESP_GAP = cst_pkg::RESP_GAP_DEFAULT
) (
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              clk_link,
  input wire logic              cmd_out,
  input wire logic              cmd_oe_n,
  input wire cst_pkg::cst_evt_t evt,
  input wire cst_pkg::cst_lvl_t lvl,
  input wire logic              cmd_take,
  input wire logic [31:0]       status_word
);
  logic [5:0] pos;
  logic [5:0] next_pos;
  logic [3:0] since;
  logic [3:0] next_since;
  logic [1:0] up;
  logic [1:0] next_up;
  logic       drv0;

  // Frame start counts only from idle, so zeros inside a frame never retrigger
  assign drv0 = !cmd_oe_n && !cmd_out;
  always_comb
  begin
    next_pos = (pos == 6'h2f) ? 6'h00 : ((pos != 6'h00 || drv0) ? pos + 6'h01 : 6'h00);
  end
  always_ff @(posedge clk_link or posedge rst)
  begin
    if (rst)
      pos <= 6'h00;
    else
      pos <= next_pos;
  end

  // Cycles since the last taken command; settling count after reset
  always_comb
  begin
    next_since = cmd_take ? 4'h0 : ((since == 4'hf) ? since : since + 4'h1);
    next_up = (up == 2'h3) ? up : up + 2'h1;
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      since <= 4'hf;
      up <= 2'h0;
    end
    else
    begin
      since <= next_since;
      up <= next_up;
    end
  end

  sequence s_start;
    pos == 6'h00 && drv0;
  endsequence
  sequence s_tail;
    ##47 !drv0 ##1 cmd_oe_n;
  endsequence

  property p_tx_bit;
    @(posedge clk_link) disable iff (rst) s_start |=> drv0;
  endproperty
  a_tx_bit: assert property (p_tx_bit)
    else $error("transmitter bit not low");
  property p_frame;
    @(posedge clk_link) disable iff (rst) s_start |-> s_tail;
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame end or release wrong");
  property p_pull;
    @(posedge clk_link) disable iff (rst) $fell(cmd_oe_n) && cmd_out |-> ##[1:62] drv0;
  endproperty
  a_pull: assert property (p_pull)
    else $error("pull-up bits without start");
  property p_levels;
    @(posedge clk_sys) disable iff (rst)
      up == 2'h3 && lvl == $past(lvl) && lvl == $past(lvl, 2) |->
      {status_word[25], status_word[14], status_word[12:8]} ==
      {lvl.locked_flag, lvl.ecc_off, lvl.state, lvl.buf_empty};
  endproperty
  a_levels: assert property (p_levels)
    else $error("level bits do not follow");
  property p_zero;
    @(posedge clk_sys) disable iff (rst) status_word[7:6] == 2'h0 && !status_word[4];
  endproperty
  a_zero: assert property (p_zero)
    else $error("fixed zero bits set");
  property p_range;
    @(posedge clk_sys) disable iff (rst) evt.arg_range_fault |-> ##[1:2] status_word[31];
  endproperty
  a_range: assert property (p_range)
    else $error("range fault not captured");
  property p_ctrl;
    @(posedge clk_sys) disable iff (rst) $rose(evt.controller_fault) |=> ##[0:1] status_word[20];
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("controller fault not captured");
  property p_clear;
    @(posedge clk_sys) disable iff (rst) $fell(status_word[31]) |-> since <= 4'h6;
  endproperty
  a_clear: assert property (p_clear)
    else $error("sticky bit cleared without command");
endmodule : cst_card_status_asserts

bind cst_card_status cst_card_status_asserts #(.RESP_GAP(RESP_GAP)) u_cst_card_status_asserts (
  .clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .cmd_out(cmd_out),
  .cmd_oe_n(cmd_oe_n), .evt(evt), .lvl(lvl), .cmd_take(cmd_take),
  .status_word(status_word)
);

// ---- bench/cst_host_model.sv ----
`timescale 1ns/1ps

module cst_host_model (
  output logic      clk_link,
  output logic      cmd_in,
  input  wire logic cmd_out,
  input  wire logic cmd_oe_n
);
  logic        ck;
  logic        run;
  logic        h_oe;
  logic        h_bit;
  logic [7:0]  rgap;
  logic [47:0] rframe;
  event        done;

  // Link clock stands still between transfers; released line reads pull-up
  assign clk_link = ck & run;
  assign cmd_in = h_oe ? h_bit : (cmd_oe_n ? 1'b1 : cmd_out);
  initial
  begin
    ck = 1'b0;
    run = 1'b0;
    h_oe = 1'b0;
    h_bit = 1'b1;
    #3;
    forever #6 ck = ~ck;
  end

  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ ({7{d[i] ^ c[6]}} & 7'h09);
    return c;
  endfunction : crc7

  task automatic clocks(input int n);
    @(negedge ck) run = 1'b1;
    repeat (n) @(posedge clk_link);
    @(negedge ck) run = 1'b0;
  endtask : clocks

  // Host bits change just after the rising edge
  task automatic xfer(input logic [5:0] idx, input logic [31:0] arg, input logic bad);
    logic [47:0] f;
    int          k;
    f = {2'b01, idx, arg, 8'h01};
    f[7:1] = crc7(f[47:8]) ^ {6'h00, bad};
    @(negedge ck) run = 1'b1;
    for (int i = 47; i >= 0; i--)
    begin
      @(posedge clk_link);
      #1;
      h_oe = 1'b1;
      h_bit = f[i];
    end
    @(posedge clk_link);
    #1;
    h_oe = 1'b0;
    k = 0;
    while (k < 70 && cmd_in)
    begin
      @(posedge clk_link);
      #1;
      k++;
    end
    if (k < 70)
    begin
      rframe[47] = 1'b0;
      for (int i = 46; i >= 0; i--)
      begin
        @(posedge clk_link);
        #1;
        rframe[i] = cmd_in;
      end
      rgap = 8'(k);
      -> done;
    end
    // Silence past the longest answer window counts as no response
    repeat (8) @(posedge clk_link);
    @(negedge ck) run = 1'b0;
  endtask : xfer
endmodule : cst_host_model

// ---- bench/tb.sv ----
`timescale 1ns/1ps

module tb;
  localparam int unsigned GAP = 10;
  logic                    clk_sys;
  logic                    rst;
  logic                    clk_link;
  logic                    cmd_in;
  logic                    cmd_out;
  logic                    cmd_oe_n;
  cst_pkg::cst_evt_t       evt;
  cst_pkg::cst_lvl_t       lvl;
  cst_pkg::cst_resp_kind_t resp_sel;
  logic [31:0]             ident_word;
  logic                    cmd_take;
  cst_pkg::cst_cmd_t       cmd_info;
  logic [31:0]             status_word;
  logic [31:0]             sticky;
  logic [15:0]             lfsr;
  logic [55:0]             rq[$];
  logic [37:0]             cq[$];
  int                      fails;
  int                      cmp_count;

  cst_card_status #(.RESP_GAP(GAP)) u_cst_card_status (
    .clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .cmd_in(cmd_in),
    .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n), .evt(evt), .lvl(lvl),
    .resp_sel(resp_sel), .ident_word(ident_word), .cmd_take(cmd_take),
    .cmd_info(cmd_info), .status_word(status_word)
  );
  cst_host_model u_cst_host_model (
    .clk_link(clk_link), .cmd_in(cmd_in), .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  // Expected status: captured event bits plus the live levels
  function automatic logic [31:0] stat(input logic [16:0] e);
    int          p[17] = '{5, 13, 15, 16, 17, 18, 19, 20, 21, 22, 24, 26, 27, 28, 29, 30, 31};
    logic [31:0] r;
    r = {6'h00, lvl.locked_flag, 10'h000, lvl.ecc_off, 1'b0, lvl.state, lvl.buf_empty, 8'h00};
    for (int i = 0; i < 17; i++)
      r[p[i]] = e[i];
    return r;
  endfunction : stat

  task automatic chk_word(input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_word

  task automatic chk_frame(input logic [55:0] e, input logic [55:0] g);
    chk_word({8'h00, e}, {8'h00, g});
  endtask : chk_frame

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // One command: random levels and events, then notes of what must come back
  task automatic run_cmd(input cst_pkg::cst_resp_kind_t k, input logic bad);
    logic [5:0]  ix;
    logic [31:0] a;
    logic [39:0] h;
    ix = 6'(rnd());
    a = {rnd(), rnd()};
    @(posedge clk_sys);
    #1;
    lvl.state = 4'(rnd() % 16'h0009);
    {lvl.locked_flag, lvl.ecc_off, lvl.buf_empty} = 3'(rnd());
    resp_sel = k;
    ident_word = {rnd(), rnd()};
    evt = 17'({rnd(), rnd()});
    sticky = sticky | stat(evt) & ~stat(17'h0);
    @(posedge clk_sys);
    #1;
    evt = '0;
    repeat (3) @(posedge clk_sys);
    chk_word(sticky | stat(17'h0), status_word);
    h = {2'b00, ix, sticky | stat(17'h0)};
    if (!bad)
      cq.push_back({ix, a});
    if (!bad && k == cst_pkg::RK_OPEN)
      rq.push_back({8'h05, 2'b00, 6'h3f, ident_word, 8'hff});
    else if (!bad && k != cst_pkg::RK_NONE)
    begin
      rq.push_back({8'(GAP), h, u_cst_host_model.crc7(h), 1'b1});
      sticky = '0;
    end
    u_cst_host_model.xfer(ix, a, bad);
    if (bad)
      sticky[23] = 1'b1;
  endtask : run_cmd

  // Each response seen by the host is matched with the oldest note
  always @(u_cst_host_model.done)
  begin
    if (rq.size() == 0)
      chk_frame('1, {u_cst_host_model.rgap, u_cst_host_model.rframe});
    else
      chk_frame(rq.pop_front(), {u_cst_host_model.rgap, u_cst_host_model.rframe});
  end
  always @(posedge clk_sys)
  begin
    if (cmd_take === 1'b1)
      chk_word((cq.size() == 0) ? '1 : cq.pop_front(), cmd_info);
  end

  initial
  begin
    lfsr = 16'h001e;
    fails = 0;
    cmp_count = 0;
    sticky = '0;
    rst = 1'b1;
    evt = '0;
    lvl = '0;
    resp_sel = cst_pkg::RK_NONE;
    ident_word = '0;
    // Link reset needs its own edges as well as the system ones
    fork
      repeat (4) @(posedge clk_sys);
      u_cst_host_model.clocks(4);
    join
    chk_word(cst_pkg::STATUS_RESET, status_word);
    @(posedge clk_sys);
    #1;
    rst = 1'b0;
    u_cst_host_model.clocks(3);
    $display("test reset done");
    for (int p = 0; p < 2; p++)
      for (int k = 0; k < 4; k++)
        run_cmd(cst_pkg::cst_resp_kind_t'(k), 1'b0);
    $display("test response kinds done");
    run_cmd(cst_pkg::RK_OPEN, 1'b1);
    run_cmd(cst_pkg::RK_R1, 1'b0);
    run_cmd(cst_pkg::RK_R1_NOPULL, 1'b0);
    $display("test check fault done");
    chk_word(64'h0, 64'(rq.size() + cq.size()));
    conclude();
  end

  // Eleven transfers take about 16 us; the limit leaves wide margin
  initial
  begin
    #200000;
    fails++;
    conclude();
  end
endmodule : tb
